//--- core/sff_spi_front.sv
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module sff_spi_front
  import sff_pkg::*;
#(
  parameter logic [7:0] OP_WRITE_ENABLE   = 8'h06,
  parameter logic [7:0] OP_WRITE_STATUS   = 8'h01,
  parameter logic [7:0] OP_READ_STATUS_LO = 8'h05,
  parameter logic [7:0] OP_READ_STATUS_HI = 8'h35
) (
  input  wire logic        hclk,          // Bus clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  output logic [31:0]      hrdata,        // Read data
  input  wire logic        supply_ok,     // Supply above reset threshold
  input  wire logic        cs_n,          // Select, active low
  input  wire logic        sclk,          // Shift clock
  input  wire logic [3:0]  data_line_in,  // Data lines 3..0 in
  output logic [3:0]       data_line_out, // Data lines 3..0 out
  output logic [3:0]       data_line_oe,  // Data line drive enables
  output logic             active_mode,   // Selected
  output logic             standby_mode,  // Deselected and idle
  output logic             pause_active   // Pause in force
);

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DOUT, ST_WDATA,
                            ST_IGNORE} sff_state_t;

  sff_pins_t   pin_raw;
  sff_pins_t   sync1_q;
  sff_pins_t   sync2_q;
  logic        sclk_d_q;
  logic        cs_d_q;
  logic        armed_q;
  logic        sel_q;
  logic        pause_q;
  sff_state_t  state_q;
  logic [5:0]  cnt_q;
  logic [23:0] shreg_q;
  logic [23:0] sh_next;
  sff_lanes_t  addr_ln_q;
  sff_lanes_t  data_ln_q;
  sff_lanes_t  in_ln;
  logic [5:0]  dummy_q;
  sff_src_t    src_q;
  logic [7:0]  cap_op_q;
  logic [23:0] cap_addr_q;
  logic [7:0]  st_lo_q;
  logic [7:0]  st_hi_q;
  logic        wsr_ok_q;
  logic [7:0]  tx_q;
  logic [2:0]  ocnt_q;
  logic [7:0]  ob_q;
  logic        started_q;
  logic [3:0]  dout_q;
  logic [3:0]  oe_q;
  logic        wr_pend_q;
  logic [7:0]  wa_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic        active_q;
  logic        standby_q;
  logic        pause_out_q;

  logic        por_ok;
  logic        hold_n;
  logic        wp_n;
  logic        sel_start;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cmd_done;
  logic [7:0]  op_now;
  logic        wsr_lo_done;
  logic        wsr_hi_done;
  logic        locked;
  logic        wsr_allowed;
  logic        ap;
  logic [7:0]  src_byte;

  function automatic logic [3:0] place(input logic [7:0] b, input sff_lanes_t ln);
    unique case (ln)
      LN1:     place = {2'b00, b[7], 1'b0};
      LN2:     place = {2'b00, b[7:6]};
      default: place = b[7:4];
    endcase
  endfunction

  function automatic logic [7:0] shl(input logic [7:0] b, input sff_lanes_t ln);
    unique case (ln)
      LN1:     shl = {b[6:0], 1'b0};
      LN2:     shl = {b[5:0], 2'b00};
      default: shl = {b[3:0], 4'h0};
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input sff_lanes_t ln);
    unique case (ln)
      LN1:     lane_mask = 4'h2;
      LN2:     lane_mask = 4'h3;
      default: lane_mask = 4'hF;
    endcase
  endfunction

  // Pins cross into hclk through two flops before anything looks at them
  assign pin_raw = '{supply_ok: supply_ok, cs_n: cs_n, sclk: sclk, data_line: data_line_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q  <= PINS_RST;
      sync2_q  <= PINS_RST;
      sclk_d_q <= 1'b0;
      cs_d_q   <= 1'b1;
    end else begin
      sync1_q  <= pin_raw;
      sync2_q  <= sync1_q;
      sclk_d_q <= sync2_q.sclk;
      cs_d_q   <= sync2_q.cs_n;
    end
  end

  assign por_ok    = sync2_q.supply_ok;
  // With quad enable set the pause and protect pins are data lines only
  assign hold_n    = st_hi_q[HI_QE] | sync2_q.data_line[3];
  assign wp_n      = st_hi_q[HI_QE] | sync2_q.data_line[2];
  assign sel_start = por_ok & armed_q & cs_d_q & ~sync2_q.cs_n;
  // Edges count only when selected and not paused; idle level is irrelevant
  assign sclk_rise = sel_q & ~pause_q & sync2_q.sclk & ~sclk_d_q;
  assign sclk_fall = sel_q & ~pause_q & ~sync2_q.sclk & sclk_d_q;

  // Select tracking: must see select high before a falling edge counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 1'b0;
      sel_q   <= 1'b0;
    end else if (!por_ok) begin
      armed_q <= 1'b0;
      sel_q   <= 1'b0;
    end else if (sync2_q.cs_n) begin
      armed_q <= 1'b1;
      sel_q   <= 1'b0;
    end else if (sel_start) begin
      sel_q   <= 1'b1;
    end
  end

  // Pause follows the pause pin only while the clock sits low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_q <= 1'b0;
    end else if (!sel_q || !por_ok) begin
      pause_q <= 1'b0;
    end else if (!sync2_q.sclk) begin
      pause_q <= ~hold_n;
    end
  end

  always_comb begin
    in_ln = (state_q == ST_ADDR) ? addr_ln_q : LN1;
    unique case (in_ln)
      LN1:     sh_next = {shreg_q[22:0], sync2_q.data_line[0]};
      LN2:     sh_next = {shreg_q[21:0], sync2_q.data_line[1:0]};
      default: sh_next = {shreg_q[19:0], sync2_q.data_line[3:0]};
    endcase
  end

  assign op_now      = sh_next[7:0];
  assign cmd_done    = sclk_rise && (state_q == ST_CMD) && (cnt_q == 6'h01);
  assign wsr_lo_done = sclk_rise && (state_q == ST_WDATA) && (cnt_q == WSR_LO_AT);
  assign wsr_hi_done = sclk_rise && (state_q == ST_WDATA) && (cnt_q == 6'h01);

  // Transaction sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 6'h00;
      shreg_q    <= 24'h00_0000;
      addr_ln_q  <= LN1;
      data_ln_q  <= LN1;
      dummy_q    <= 6'h00;
      src_q      <= SRC_TX;
      cap_op_q   <= 8'h00;
      cap_addr_q <= 24'h00_0000;
    end else if (sel_start) begin
      state_q <= ST_CMD;
      cnt_q   <= CMD_CLKS;
    end else if (!sel_q || !por_ok) begin
      state_q <= ST_IDLE;
    end else if (sclk_rise) begin
      unique case (state_q)
        ST_CMD: begin
          shreg_q <= sh_next;
          cnt_q   <= cnt_q - 6'h01;
          if (cmd_done) begin
            cap_op_q <= op_now;
            src_q    <= SRC_TX;
            state_q  <= ST_ADDR;
            if (op_now == OP_DUAL_OUT) begin
              addr_ln_q <= LN1;
              data_ln_q <= LN2;
              dummy_q   <= DUMMY_DUAL_OUT;
              cnt_q     <= ADDR_CLKS_1;
            end else if (op_now == OP_DUAL_IO) begin
              addr_ln_q <= LN2;
              data_ln_q <= LN2;
              dummy_q   <= DUMMY_DUAL_IO;
              cnt_q     <= ADDR_CLKS_2;
            end else if (op_now == OP_QUAD_OUT && st_hi_q[HI_QE]) begin
              addr_ln_q <= LN1;
              data_ln_q <= LN4;
              dummy_q   <= DUMMY_QUAD_OUT;
              cnt_q     <= ADDR_CLKS_1;
            end else if (op_now == OP_QUAD_IO && st_hi_q[HI_QE]) begin
              addr_ln_q <= LN4;
              data_ln_q <= LN4;
              dummy_q   <= DUMMY_QUAD_IO;
              cnt_q     <= ADDR_CLKS_4;
            end else if (op_now == OP_READ_STATUS_LO || op_now == OP_READ_STATUS_HI) begin
              data_ln_q <= LN1;
              src_q     <= (op_now == OP_READ_STATUS_LO) ? SRC_LO : SRC_HI;
              state_q   <= ST_DOUT;
            end else if (op_now == OP_WRITE_STATUS) begin
              state_q <= ST_WDATA;
              cnt_q   <= WSR_CLKS;
            end else begin
              // Quad codes without quad enable fall here and are ignored
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          shreg_q <= sh_next;
          cnt_q   <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            cap_addr_q <= sh_next;
            cnt_q      <= dummy_q;
            state_q    <= (dummy_q == 6'h00) ? ST_DOUT : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            state_q <= ST_DOUT;
          end
        end
        ST_WDATA: begin
          shreg_q <= sh_next;
          cnt_q   <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            state_q <= ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Status write protection: hi guard locks outright, lo guard defers to the pin
  assign locked      = st_hi_q[HI_GUARD] | (st_lo_q[LO_GUARD] & ~wp_n);
  assign wsr_allowed = st_lo_q[LO_WEL] & ~st_lo_q[LO_BUSY] & ~locked;

  // Status registers; bus writes first so that link events override them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_lo_q  <= ST_LO_RST;
      st_hi_q  <= ST_HI_RST;
      wsr_ok_q <= 1'b0;
    end else if (!por_ok) begin
      st_lo_q[LO_WEL] <= 1'b0;
      st_hi_q[HI_SUS] <= 1'b0;
      wsr_ok_q        <= 1'b0;
      // Power-cycle lock-down unlocks at the next supply cycle
      if (st_hi_q[HI_GUARD] && !st_lo_q[LO_GUARD]) begin
        st_hi_q[HI_GUARD] <= 1'b0;
      end
    end else begin
      if (wr_pend_q && wa_q == ADDR_STATUS) begin
        st_lo_q <= (st_lo_q & ~LO_NV_MASK) | (hwdata[7:0] & LO_NV_MASK);
        st_hi_q <= (st_hi_q & ~HI_SW_MASK) | (hwdata[15:8] & HI_SW_MASK);
      end
      if (wr_pend_q && wa_q == ADDR_CTRL) begin
        st_lo_q[LO_BUSY] <= hwdata[CTRL_BUSY];
        if (hwdata[CTRL_WEL_CLR]) begin
          st_lo_q[LO_WEL] <= 1'b0;
        end
      end
      if (cmd_done) begin
        if (op_now == OP_WRITE_ENABLE && !st_lo_q[LO_BUSY]) begin
          st_lo_q[LO_WEL] <= 1'b1;
        end
        if (op_now == OP_SUSPEND) begin
          st_hi_q[HI_SUS] <= 1'b1;
        end
        if (op_now == OP_RESUME) begin
          st_hi_q[HI_SUS] <= 1'b0;
        end
      end
      if (wsr_lo_done) begin
        wsr_ok_q <= wsr_allowed;
        if (wsr_allowed) begin
          st_lo_q <= (st_lo_q & ~LO_NV_MASK) | (op_now & LO_NV_MASK);
          st_lo_q[LO_WEL] <= 1'b0;
        end
      end
      if (wsr_hi_done && wsr_ok_q) begin
        // Over the link, lock bits can only be set, never cleared
        st_hi_q <= (st_hi_q & ~HI_RW_MASK) | (op_now & HI_RW_MASK) | (op_now & HI_OTP_MASK);
      end
    end
  end

  always_comb begin
    unique case (src_q)
      SRC_LO:  src_byte = st_lo_q;
      SRC_HI:  src_byte = st_hi_q;
      default: src_byte = tx_q;
    endcase
  end

  // Output shifter: new bits go out after each falling edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ocnt_q    <= 3'h0;
      ob_q      <= 8'h00;
      started_q <= 1'b0;
      dout_q    <= 4'h0;
    end else if (!sel_q || state_q != ST_DOUT) begin
      ocnt_q    <= 3'h0;
      started_q <= 1'b0;
    end else if (sclk_fall) begin
      started_q <= 1'b1;
      if (ocnt_q == 3'h0) begin
        dout_q <= place(src_byte, data_ln_q);
        ob_q   <= shl(src_byte, data_ln_q);
        unique case (data_ln_q)
          LN1:     ocnt_q <= CPB_1;
          LN2:     ocnt_q <= CPB_2;
          default: ocnt_q <= CPB_4;
        endcase
      end else begin
        dout_q <= place(ob_q, data_ln_q);
        ob_q   <= shl(ob_q, data_ln_q);
        ocnt_q <= ocnt_q - 3'h1;
      end
    end
  end

  // Drivers float in pause or when deselected; shifter position is kept in pause, cleared on deselect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_q <= 4'h0;
    end else if (sel_q && por_ok && !pause_q && state_q == ST_DOUT && started_q) begin
      oe_q <= lane_mask(data_ln_q);
    end else begin
      oe_q <= 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q    <= 1'b0;
      standby_q   <= 1'b0;
      pause_out_q <= 1'b0;
    end else begin
      active_q    <= sel_q;
      standby_q   <= ~sel_q & ~st_lo_q[LO_BUSY];
      pause_out_q <= pause_q;
    end
  end

  // Bus slave: zero wait states, read data registered in the address phase
  assign ap = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wa_q        <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q <= ap & hwrite & (hsize == 3'h2) & (haddr[31:8] == 24'h00_0000);
      if (ap) begin
        wa_q <= haddr[7:0];
      end
      if (ap && !hwrite) begin
        if (haddr[31:8] != 24'h00_0000) begin
          hrdata_q <= 32'h0000_0000;
        end else begin
          unique case (haddr[7:0])
            ADDR_STATUS:  hrdata_q <= {16'h0000, st_hi_q, st_lo_q};
            ADDR_CTRL:    hrdata_q <= {20'h0_0000, 1'b0, standby_q, pause_q, sel_q,
                                       6'h00, 1'b0, st_lo_q[LO_BUSY]};
            ADDR_TXDATA:  hrdata_q <= {24'h00_0000, tx_q};
            ADDR_CAPTURE: hrdata_q <= {cap_addr_q, cap_op_q};
            default:      hrdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q <= 8'h00;
    end else if (wr_pend_q && wa_q == ADDR_TXDATA) begin
      tx_q <= hwdata[7:0];
    end
  end

  assign hreadyout     = hreadyout_q;
  assign hresp         = hresp_q;
  assign hrdata        = hrdata_q;
  assign data_line_out = dout_q;
  assign data_line_oe  = oe_q;
  assign active_mode   = active_q;
  assign standby_mode  = standby_q;
  assign pause_active  = pause_out_q;

endmodule

//--- core/sff_pkg.sv
package sff_pkg;

  // Instruction codes
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO  = 8'hEB;
  localparam logic [7:0] OP_SUSPEND  = 8'h75;
  localparam logic [7:0] OP_RESUME   = 8'h7A;

  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_TXDATA  = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE = 8'h0C;

  // Lower status byte fields
  localparam int LO_GUARD = 7;
  localparam int LO_WEL   = 1;
  localparam int LO_BUSY  = 0;
  // Upper status byte fields
  localparam int HI_SUS   = 7;
  localparam int HI_QE    = 1;
  localparam int HI_GUARD = 0;
  // Control register fields
  localparam int CTRL_BUSY    = 0;
  localparam int CTRL_WEL_CLR = 1;

  localparam logic [7:0] ST_LO_RST   = 8'h00;
  localparam logic [7:0] ST_HI_RST   = 8'h00;
  localparam logic [7:0] LO_NV_MASK  = 8'hFC;
  localparam logic [7:0] HI_SW_MASK  = 8'h7B;
  localparam logic [7:0] HI_RW_MASK  = 8'h43;
  localparam logic [7:0] HI_OTP_MASK = 8'h38;

  // Phase lengths in shift clocks
  localparam logic [5:0] CMD_CLKS       = 6'h08;
  localparam logic [5:0] ADDR_CLKS_1    = 6'h18;
  localparam logic [5:0] ADDR_CLKS_2    = 6'h0C;
  localparam logic [5:0] ADDR_CLKS_4    = 6'h06;
  localparam logic [5:0] WSR_CLKS       = 6'h10;
  localparam logic [5:0] WSR_LO_AT      = 6'h09;
  localparam logic [5:0] DUMMY_DUAL_OUT = 6'h08;
  localparam logic [5:0] DUMMY_DUAL_IO  = 6'h04;
  localparam logic [5:0] DUMMY_QUAD_OUT = 6'h08;
  localparam logic [5:0] DUMMY_QUAD_IO  = 6'h06;
  localparam logic [2:0] CPB_1          = 3'h7;
  localparam logic [2:0] CPB_2          = 3'h3;
  localparam logic [2:0] CPB_4          = 3'h1;

  typedef enum logic [1:0] {LN1, LN2, LN4} sff_lanes_t;
  typedef enum logic [1:0] {SRC_TX, SRC_LO, SRC_HI} sff_src_t;

  typedef struct packed {
    logic       supply_ok;
    logic       cs_n;
    logic       sclk;
    logic [3:0] data_line;
  } sff_pins_t;

  localparam sff_pins_t PINS_RST = '{supply_ok: 1'b0, cs_n: 1'b1, sclk: 1'b0, data_line: 4'h0};

endpackage

//--- test/sff_spi_front_monitor.sv
`timescale 1ns/1ps
module sff_spi_front_monitor (
  input wire logic       hclk,          // Clock
  input wire logic       hresetn,       // Reset, active low
  input wire logic       supply_ok,     // Supply good
  input wire logic       cs_n,          // Select, active low
  input wire logic       sclk,          // Shift clock
  input wire logic [3:0] data_line_in,  // Lines in
  input wire logic [3:0] data_line_out, // Lines out
  input wire logic [3:0] data_line_oe,  // Line enables
  input wire logic       active_mode,   // Selected
  input wire logic       standby_mode,  // Standby
  input wire logic       pause_active   // Pause in force
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_desel_float; cs_n [*8] |-> data_line_oe == 4'h0; endproperty
  a_desel_float: assert property (p_desel_float) else $error("lines driven unselected");
  property p_act_sb; active_mode |-> !standby_mode; endproperty
  a_act_sb: assert property (p_act_sb) else $error("standby while active");
  property p_por_act; !supply_ok [*6] |-> !active_mode; endproperty
  a_por_act: assert property (p_por_act) else $error("active with low supply");
  property p_por_oe; !supply_ok [*6] |-> data_line_oe == 4'h0; endproperty
  a_por_oe: assert property (p_por_oe) else $error("driving with low supply");
  property p_pause_float; pause_active [*4] |-> data_line_oe == 4'h0; endproperty
  a_pause_float: assert property (p_pause_float) else $error("driving in pause");
  property p_pause_sel; $rose(pause_active) |-> active_mode; endproperty
  a_pause_sel: assert property (p_pause_sel) else $error("pause while unselected");
  property p_pause_sclk; sclk [*6] |=> !$rose(pause_active); endproperty
  a_pause_sclk: assert property (p_pause_sclk) else $error("pause began, clock high");
  property p_pause_pin; data_line_in[3] [*6] |=> !$rose(pause_active); endproperty
  a_pause_pin: assert property (p_pause_pin) else $error("pause without pin low");
  property p_oe_codes; data_line_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
  a_oe_codes: assert property (p_oe_codes) else $error("bad lane enables");
  property p_out_steady; (sclk && !cs_n) [*6] |=> $stable(data_line_out); endproperty
  a_out_steady: assert property (p_out_steady) else $error("output moved, clock high");
  c_dual: cover property (data_line_oe == 4'h3);
  c_quad: cover property (data_line_oe == 4'hF);
  c_pause: cover property ($rose(pause_active));
endmodule

bind sff_spi_front sff_spi_front_monitor i_mon (
  .hclk, .hresetn, .supply_ok, .cs_n, .sclk, .data_line_in,
  .data_line_out, .data_line_oe, .active_mode, .standby_mode, .pause_active
);

//--- test/sff_host_model.sv
`timescale 1ns/1ps
module sff_host_model (
  output logic            cs_n, // Select, active low
  output logic            sclk, // Shift clock
  output logic [3:0]      drv,  // Host drive of lines
  input  wire logic [3:0] line  // Resolved lines
);
  logic       idle_hi;
  logic [3:0] smp;
  // Select low from power-up on purpose: the device must wait for a fall
  initial begin
    cs_n    = 1'b0;
    sclk    = 1'b0;
    idle_hi = 1'b0;
    drv     = 4'hD;
    smp     = 4'h0;
  end
  // Released lines toggle so a stale value never looks right
  task automatic tick(input logic [3:0] d, input int w);
    sclk = 1'b0;
    drv[1:0] = (w == 1) ? {~drv[1], d[0]} : d[1:0];
    if (w == 4) drv[3:2] = d[3:2];
    #62.5;
    sclk = 1'b1;
    smp = line;
    #62.5;
  endtask
  task automatic send(input logic [31:0] x, input int n, input int w);
    for (int i = n - 1; i >= 0; i--) tick(4'(x >> (i * w)), w);
  endtask
  task automatic skip(input int n, input int w);
    for (int i = 0; i < n; i++) tick(~drv, w);
  endtask
  task automatic recv(input int w, output logic [7:0] x);
    x = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      tick(~drv, w);
      x = (x << w) | 8'(w == 1 ? {3'h0, smp[1]} : (w == 2 ? {2'h0, smp[1:0]} : smp));
    end
  endtask
  task automatic start();
    sclk = idle_hi;
    #100;
    cs_n = 1'b0;
    #62.5;
  endtask
  task automatic stop();
    sclk = idle_hi;
    #62.5;
    cs_n = 1'b1;
    drv = {2'b11, ~drv[1:0]};
    #400;
  endtask
  task automatic mode(input logic hi);
    idle_hi = hi;
    sclk = hi;
    #200;
  endtask
  // Pause and protect pins, then the clock level
  task automatic pin(input logic p, input logic w, input logic s);
    drv[3:2] = {p, w};
    #100;
    sclk = s;
    #100;
  endtask
endmodule

//--- test/test_serial_flash_spi_front_end.sv
`timescale 1ns/1ps
module test_serial_flash_spi_front_end;
  import sff_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, supply_ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  dl_in, dl_out, dl_oe, h_drv;
  logic        cs_n, sclk, act, stby, pse, oe_hit;
  logic [7:0]  v;
  logic [7:0]  fop [4] = '{OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO};
  int          fna [4] = '{24, 12, 24, 6};
  int          faw [4] = '{1, 2, 1, 4};
  int          fnd [4] = '{8, 4, 8, 6};
  int          fw  [4] = '{2, 2, 4, 4};
  int          n_errors = 0;
  int          n_compared = 0;
  assign hready = hreadyout;
  assign dl_in  = (dl_oe & dl_out) | (~dl_oe & h_drv);
  sff_spi_front i_sff_spi_front (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .supply_ok, .cs_n, .sclk, .data_line_in(dl_in),
    .data_line_out(dl_out), .data_line_oe(dl_oe), .active_mode(act),
    .standby_mode(stby), .pause_active(pse)
  );
  sff_host_model u_host (.cs_n, .sclk, .drv(h_drv), .line(dl_in));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) if (dl_oe != 4'h0) oe_hit <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    for (int t = 0; hready !== 1'b1; t++) begin
      if (t == 20) n_errors++;
      if (t == 20) end_sim();
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rs(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask
  task automatic op(input logic [7:0] c);
    u_host.start();
    u_host.send(c, 8, 1);
    u_host.stop();
  endtask
  task automatic wsr(input logic [15:0] b);
    u_host.start();
    u_host.send(8'h01, 8, 1);
    u_host.send(b, 16, 1);
    u_host.stop();
  endtask
  task automatic rx(input logic [7:0] c, input int na, input int aw, input int nd, input int w);
    u_host.start();
    u_host.send(c, 8, 1);
    u_host.send(32'h0012_3456, na, aw);
    u_host.skip(nd, aw);
    u_host.recv(w, v);
    u_host.stop();
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    end_sim();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    supply_ok = 1'b0;
    oe_hit = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    supply_ok <= 1'b1;
    rs(ADDR_STATUS, 32'h0000_0000);
    chk(stby, 1'b1);
    // Select has been low since power-up, so no fall was seen yet
    u_host.send(8'h06, 8, 1);
    u_host.stop();
    rs(ADDR_STATUS, 32'h0000_0000);
    op(8'h06);
    rs(ADDR_STATUS, 32'h0000_0002);
    supply_ok <= 1'b0;
    op(8'h06);
    rs(ADDR_STATUS, 32'h0000_0000);
    supply_ok <= 1'b1;
    repeat (10) @(posedge hclk);
    bus(1'b1, ADDR_STATUS, 32'h0000_C27F);
    rs(ADDR_STATUS, 32'h0000_427C);
    $display("test power and fields done");
    for (int m = 0; m < 2; m++) begin
      u_host.mode(m[0]);
      rx(8'h05, 0, 1, 0, 1);
      chk(v, 8'h7C);
      rx(8'h35, 0, 1, 0, 1);
      chk(v, 8'h42);
    end
    u_host.mode(1'b0);
    bus(1'b1, ADDR_TXDATA, 32'h0000_00A5);
    for (int i = 0; i < 4; i++) begin
      rx(fop[i], fna[i], faw[i], fnd[i], fw[i]);
      chk(v, 8'hA5);
      rs(ADDR_CAPTURE, {24'h12_3456, fop[i]});
    end
    bus(1'b1, ADDR_STATUS, 32'h0000_007C);
    oe_hit = 1'b0;
    rx(OP_QUAD_OUT, 24, 1, 8, 4);
    rx(OP_QUAD_IO, 6, 4, 6, 4);
    chk(oe_hit, 1'b0);
    $display("test reads done");
    op(OP_SUSPEND);
    rs(ADDR_STATUS, 32'h0000_807C);
    op(OP_RESUME);
    rs(ADDR_STATUS, 32'h0000_007C);
    wsr(16'h8008);
    rs(ADDR_STATUS, 32'h0000_007C);
    op(8'h06);
    wsr(16'h8008);
    rs(ADDR_STATUS, 32'h0000_0880);
    // Host stop releases the protect pin, so pull it low only after the enable
    op(8'h06);
    u_host.pin(1'b1, 1'b0, 1'b0);
    wsr(16'h0000);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'hFFFF_FFFD, 32'h0000_0880);
    u_host.pin(1'b1, 1'b1, 1'b0);
    op(8'h06);
    wsr(16'h0000);
    rs(ADDR_STATUS, 32'h0000_0800);
    bus(1'b1, ADDR_CTRL, 32'h0000_0001);
    rs(ADDR_STATUS, 32'h0000_0801);
    chk(stby, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    chk(stby, 1'b1);
    $display("test status writes done");
    u_host.start();
    u_host.send(8'h35, 8, 1);
    u_host.recv(1, v);
    u_host.pin(1'b0, 1'b1, 1'b1);
    chk(pse, 1'b0);
    u_host.pin(1'b0, 1'b1, 1'b0);
    chk(pse, 1'b1);
    u_host.skip(3, 1);
    chk({pse, dl_oe}, 5'h10);
    u_host.pin(1'b1, 1'b1, 1'b0);
    chk(pse, 1'b0);
    u_host.pin(1'b0, 1'b1, 1'b0);
    u_host.stop();
    chk({pse, act}, 2'b00);
    rx(8'h35, 0, 1, 0, 1);
    chk(v, 8'h08);
    $display("test pause done");
    end_sim();
  end
endmodule
